// ===== hw/sws_pkg.sv
package sws_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int NS_PER_US      = 1000;
    localparam int T_BUSRST_US    = 480;
    localparam int T_PRES_WAIT_US = 30;
    localparam int T_PRES_LEN_US  = 120;
    localparam int T_SLOT_US      = 30;
    // Least times, rounded up to whole cycles
    localparam int BUSRST_CYC    = (T_BUSRST_US * NS_PER_US
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_WAIT_CYC = (T_PRES_WAIT_US * NS_PER_US
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRES_LEN_CYC  = (T_PRES_LEN_US * NS_PER_US
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_CYC      = (T_SLOT_US * NS_PER_US
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 16;

    // ********************************
    // Command codes
    // ********************************
    localparam logic [7:0] CMD_SEARCH    = 8'hf0;
    localparam logic [7:0] CMD_READID    = 8'h33;
    localparam logic [7:0] CMD_MATCH     = 8'h55;
    localparam logic [7:0] CMD_SKIP      = 8'hcc;
    localparam logic [7:0] CMD_CONVERT   = 8'h44;
    localparam logic [7:0] CMD_RD_SENSOR = 8'hbe;
    localparam logic [7:0] CMD_RD_STAGE  = 8'haa;

    // ********************************
    // Buffer layout and counters
    // ********************************
    localparam logic [3:0] SB_TEMP_LO = 4'h0;
    localparam logic [3:0] SB_TEMP_HI = 4'h1;
    localparam logic [3:0] SB_CONFIG  = 4'h4;
    localparam logic [3:0] SB_CRC     = 4'h8;
    localparam logic [7:0] SB_FILL    = 8'hff;
    localparam logic [3:0] CFG_FILL   = 4'hf;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [5:0] ID_LAST    = 6'h3f;
    localparam logic [1:0] PH_TRUE    = 2'h0;
    localparam logic [1:0] PH_COMP    = 2'h1;
    localparam logic [1:0] PH_DIR     = 2'h2;
    localparam logic [7:0] CRC_POLY   = 8'h8c;
    localparam int         BODY_BITS  = 56;
    localparam logic [7:0]  FAMILY_DEF = 8'h5a;            // Arbitrary value
    localparam logic [47:0] SERIAL_DEF = 48'h0000_1234_5678; // Arbitrary value
    localparam logic [15:0] TEMP_RST   = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PRES, ST_ROMCMD, ST_READID, ST_MATCH, ST_SEARCH,
        ST_FUNC, ST_CONV, ST_RDSENS, ST_ADDR, ST_RDSTAGE
    } sws_state_e;

    // One CRC step, bit taken LSB first, register shifts right
    function automatic logic [7:0] sws_crc_step(input logic [7:0] c,
                                                input logic       b);
        sws_crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 8'h00);
    endfunction

    // CRC over the low 56 identity bits, starting from zero
    function automatic logic [7:0] sws_crc_body(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < BODY_BITS; i++) begin
            c = sws_crc_step(c, d[i]);
        end
        return c;
    endfunction

endpackage

// ===== hw/sws_crc8.sv
`timescale 1ns/100ps
module sws_crc8
    import sws_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       en,
    input  wire logic       din,
    output logic [7:0]      crc
);

    typedef struct packed {
        logic [7:0] crc;
    } sws_crc_s;

    sws_crc_s crc_reg;
    sws_crc_s crc_next;

    // Clear beats a shift so a restart never mixes in a stale bit
    always_comb begin
        crc_next = crc_reg;
        if (clr) begin
            crc_next.crc = 8'h00; // RULE23
        end else if (en) begin
            crc_next.crc = sws_crc_step(crc_reg.crc, din); // RULE23
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            crc_reg <= '0;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg.crc;

endmodule

// ===== hw/sws_slave.sv
// Overview of operation
// (RULE1) Bytes travel least significant bit first both ways.
// (RULE2) Data pin only pulls low or releases; released when not sending.
// (RULE3) Bus idles high; bits may be spaced arbitrarily while high.
// (RULE4) Line low past 480 us resets the bus interface.
// (RULE5) Access is init, identity command, function command, else silence.
// (RULE6) Master reset pulse is answered with a device presence pulse.
// (RULE7) Four 8-bit identity commands; function command only after one.
// (RULE8) Search sends bit and complement, drops out on mismatch.
// (RULE9) Read-identity shifts out all 64 identity bits.
// (RULE10) Match accepts function command only if all 64 bits agree.
// (RULE11) Skip selects the device without identity code.
// (RULE12) Master avoids skip plus sensor read with several devices.
// (RULE13) Convert starts exactly one conversion, result into temp bytes.
// (RULE14) Read slots after convert answer 0 while busy, 1 when done.
// (RULE15) Bus-powered case needs master strong pull-up, no polling.
// (RULE16) Sensor read sends bytes 0 to 8, byte 8 is CRC.
// (RULE17) Sensor CRC runs over bytes 0 to 7 as they leave.
// (RULE18) Reset pulse during either read abandons the transfer.
// (RULE19) Stage read takes address byte, starts at address bits 2:0.
// (RULE20) Stage byte pointer wraps from 7 to 0.
// (RULE21) Stage CRC covers command, address and eight data bytes.
// (RULE22) Stage read address replaces the stored commit destination.
// (RULE23) CRC is x^8+x^5+x^4+1, starts at zero, LSB first.
// (RULE24) Identity is family byte, 48-bit serial, CRC of low 56 bits.
// (RULE25) Sensor bytes 2,3,5,6,7 read as all ones.
// (RULE26) Config byte shows location pins low, ones in bits 7:4.
// (RULE27) Reset pulse anywhere aborts and gets a presence answer.
// (RULE28) Unknown function command leaves the device passive.
`timescale 1ns/100ps
module sws_slave
    import sws_pkg::*;
#(
    parameter logic [7:0]       FAMILY       = FAMILY_DEF,
    parameter logic [47:0]      SERIAL       = SERIAL_DEF,
    parameter logic [CNT_W-1:0] RST_CYC      = CNT_W'(BUSRST_CYC),
    parameter logic [CNT_W-1:0] PRES_LEN     = CNT_W'(PRES_LEN_CYC),
    parameter logic [CNT_W-1:0] PRES_WAIT    = CNT_W'(PRES_WAIT_CYC),
    parameter logic [CNT_W-1:0] SLOT         = CNT_W'(SLOT_CYC)
)(
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           dqIn,
    output logic                dqOut,
    output logic                dqOe,
    input  wire logic [3:0]     locPins,
    input  wire logic           convDone,
    input  wire logic [15:0]    tempIn,
    input  wire logic [63:0]    stageData,
    input  wire logic           stageWrStb,
    input  wire logic [7:0]     stageWrAddr,
    output logic                convStart,
    output logic [7:0]          commitAddr
);

    // ********************************
    // State and constants
    // ********************************
    localparam logic [55:0]      ID_BODY   = {SERIAL, FAMILY};
    localparam logic [63:0]      ID_CODE   = {sws_crc_body(ID_BODY),
                                              ID_BODY}; // RULE24

    typedef struct packed {
        sws_state_e        st;
        logic              dqPrev;
        logic              dqLevel;
        logic              drive;
        logic [CNT_W-1:0]  lowCnt;
        logic              rstSeen;
        logic [CNT_W-1:0]  tmr;
        logic              inSlot;
        logic [7:0]        rxSh;
        logic [2:0]        bitCnt;
        logic [5:0]        idx;
        logic [1:0]        phase;
        logic              miss;
        logic [3:0]        byteCnt;
        logic [2:0]        ptr;
        logic              conv;
        logic              convStart;
        logic [15:0]       temp;
        logic [7:0]        commit;
    } sws_main_s;

    sws_main_s state_reg;
    sws_main_s state_next;

    logic       fallEdge;
    logic       riseEdge;
    logic       bitEv;
    logic       txSt;
    logic       txBit;
    logic [7:0] curByte;
    logic [7:0] rxNew;
    logic [7:0] crcVal;
    logic       crcClr;
    logic       crcEn;
    logic       crcBit;

    // Sensor buffer byte by index
    function automatic logic [7:0] sensorByte(input logic [3:0]  n,
                                              input logic [15:0] t,
                                              input logic [3:0]  loc,
                                              input logic [7:0]  c);
        if (n == SB_TEMP_LO) begin
            sensorByte = t[7:0];
        end else if (n == SB_TEMP_HI) begin
            sensorByte = t[15:8];
        end else if (n == SB_CONFIG) begin
            sensorByte = {CFG_FILL, loc}; // RULE26
        end else if (n == SB_CRC) begin
            sensorByte = c;
        end else begin
            sensorByte = SB_FILL; // RULE25
        end
    endfunction

    // ********************************
    // Slot timing and bit sources
    // ********************************
    // Slots wait on the master's edge with no timeout
    assign fallEdge = state_reg.dqPrev & ~dqIn; // RULE3
    assign riseEdge = ~state_reg.dqPrev & dqIn;
    assign bitEv    = state_reg.inSlot && (state_reg.tmr == SLOT - 1'b1);
    assign rxNew    = {dqIn, state_reg.rxSh[7:1]}; // RULE1

    // Byte on the wire for both buffer reads
    assign curByte = (state_reg.st == ST_RDSENS) ?
        sensorByte(state_reg.byteCnt, state_reg.temp, locPins, crcVal) :
        ((state_reg.byteCnt == SB_CRC) ? crcVal :
         stageData[{state_reg.ptr, 3'h0} +: 8]);

    // Which states send, the bit to send, and CRC feed
    always_comb begin
        txSt   = 1'b0;
        txBit  = 1'b1;
        crcEn  = 1'b0;
        crcClr = 1'b1;
        case (state_reg.st)
            ST_READID: begin
                txSt  = 1'b1;
                txBit = ID_CODE[state_reg.idx]; // RULE9
            end
            ST_SEARCH: begin
                txSt  = (state_reg.phase != PH_DIR);
                txBit = ID_CODE[state_reg.idx] ^
                        (state_reg.phase == PH_COMP); // RULE8
            end
            ST_CONV: begin
                txSt  = 1'b1;
                txBit = ~state_reg.conv; // RULE14
            end
            ST_RDSENS, ST_RDSTAGE: begin
                txSt   = 1'b1;
                txBit  = curByte[state_reg.bitCnt]; // RULE1
                crcClr = 1'b0;
                crcEn  = bitEv && (state_reg.byteCnt != SB_CRC); // RULE17
            end
            ST_FUNC, ST_ADDR: begin
                crcClr = 1'b0;
                crcEn  = bitEv; // RULE21
            end
            default: begin
                txSt = 1'b0;
            end
        endcase
        if (bitEv && state_reg.st == ST_FUNC && state_reg.bitCnt == BIT_LAST
            && rxNew == CMD_RD_SENSOR) begin
            crcClr = 1'b1; // RULE17
        end
    end

    assign crcBit = txSt ? txBit : dqIn;

    sws_crc8 sws_crc8_inst (
        .mclk (mclk),
        .rst  (rst),
        .clr  (crcClr),
        .en   (crcEn),
        .din  (crcBit),
        .crc  (crcVal)
    );

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        state_next           = state_reg;
        state_next.dqPrev    = dqIn;
        state_next.dqLevel   = 1'b0; // RULE2
        state_next.convStart = 1'b0;
        // Low-time counter saturates at the bus reset threshold
        if (dqIn) begin
            state_next.lowCnt = '0;
        end else if (state_reg.lowCnt != RST_CYC) begin
            state_next.lowCnt = state_reg.lowCnt + 1'b1;
        end
        if (state_reg.conv && convDone) begin
            state_next.conv = 1'b0;
            state_next.temp = tempIn; // RULE13
        end
        if (stageWrStb) begin
            state_next.commit = stageWrAddr;
        end
        // Slot engine: drive only a zero bit, release at slot end
        if (state_reg.st == ST_PRES) begin
            state_next.tmr = state_reg.tmr + 1'b1;
            if (state_reg.tmr == PRES_WAIT - 1'b1) begin
                state_next.drive = 1'b1; // RULE6
            end
            if (state_reg.tmr == PRES_WAIT + PRES_LEN - 1'b1) begin
                state_next.drive  = 1'b0;
                state_next.st     = ST_ROMCMD;
                state_next.bitCnt = '0;
            end
        end else if (state_reg.st != ST_IDLE && fallEdge
                     && !state_reg.inSlot) begin
            state_next.inSlot = 1'b1;
            state_next.tmr    = '0;
            state_next.drive  = txSt & ~txBit; // RULE2
        end else if (state_reg.inSlot) begin
            state_next.tmr = state_reg.tmr + 1'b1;
            if (bitEv) begin
                state_next.inSlot = 1'b0;
                state_next.drive  = 1'b0; // RULE2
            end
        end
        if (bitEv) begin
            state_next.bitCnt = state_reg.bitCnt + 1'b1;
            state_next.rxSh   = rxNew;
            case (state_reg.st)
                ST_ROMCMD: begin
                    state_next.idx   = '0;
                    state_next.phase = PH_TRUE;
                    state_next.miss  = 1'b0;
                    if (state_reg.bitCnt == BIT_LAST) begin // RULE7
                        if (rxNew == CMD_READID) begin
                            state_next.st = ST_READID;
                        end else if (rxNew == CMD_MATCH) begin
                            state_next.st = ST_MATCH;
                        end else if (rxNew == CMD_SKIP) begin
                            state_next.st = ST_FUNC; // RULE11
                        end else if (rxNew == CMD_SEARCH) begin
                            state_next.st = ST_SEARCH;
                        end else begin
                            state_next.st = ST_IDLE; // RULE5
                        end
                    end
                end
                ST_READID: begin
                    state_next.idx = state_reg.idx + 1'b1;
                    if (state_reg.idx == ID_LAST) begin
                        state_next.st     = ST_FUNC;
                        state_next.bitCnt = '0;
                    end
                end
                ST_MATCH: begin
                    state_next.idx  = state_reg.idx + 1'b1;
                    state_next.miss = state_reg.miss
                                      | (dqIn != ID_CODE[state_reg.idx]);
                    if (state_reg.idx == ID_LAST) begin // RULE10
                        state_next.st = state_next.miss ? ST_IDLE : ST_FUNC;
                        state_next.bitCnt = '0;
                    end
                end
                ST_SEARCH: begin
                    state_next.phase = state_reg.phase + 1'b1;
                    if (state_reg.phase == PH_DIR) begin // RULE8
                        state_next.phase = PH_TRUE;
                        state_next.idx   = state_reg.idx + 1'b1;
                        if (dqIn != ID_CODE[state_reg.idx]
                            || state_reg.idx == ID_LAST) begin
                            state_next.st = ST_IDLE;
                        end
                    end
                end
                ST_FUNC: begin
                    if (state_reg.bitCnt == BIT_LAST) begin
                        state_next.byteCnt = '0;
                        if (rxNew == CMD_CONVERT) begin
                            state_next.st = ST_CONV;
                            if (!state_reg.conv) begin
                                state_next.conv      = 1'b1; // RULE13
                                state_next.convStart = 1'b1;
                            end
                        end else if (rxNew == CMD_RD_SENSOR) begin
                            state_next.st = ST_RDSENS; // RULE16
                        end else if (rxNew == CMD_RD_STAGE) begin
                            state_next.st = ST_ADDR; // RULE19
                        end else begin
                            state_next.st = ST_IDLE; // RULE28
                        end
                    end
                end
                ST_ADDR: begin
                    if (state_reg.bitCnt == BIT_LAST) begin
                        state_next.ptr    = rxNew[2:0]; // RULE19
                        state_next.commit = rxNew; // RULE22
                        state_next.st     = ST_RDSTAGE;
                    end
                end
                ST_RDSENS, ST_RDSTAGE: begin
                    if (state_reg.bitCnt == BIT_LAST) begin
                        state_next.byteCnt = state_reg.byteCnt + 1'b1;
                        // Three-bit pointer wraps on its own
                        state_next.ptr = state_reg.ptr + 1'b1; // RULE20
                        if (state_reg.byteCnt == SB_CRC) begin
                            state_next.st = ST_IDLE; // RULE16
                        end
                    end
                end
                default: begin
                    state_next.rxSh = rxNew;
                end
            endcase
        end
        // Long low level aborts anything, even mid-read
        if (!dqIn && state_reg.lowCnt == RST_CYC - 1'b1) begin
            state_next.st      = ST_IDLE; // RULE4 RULE18
            state_next.rstSeen = 1'b1;
            state_next.drive   = 1'b0;
            state_next.inSlot  = 1'b0;
        end else if (state_reg.rstSeen && riseEdge) begin
            state_next.rstSeen = 1'b0;
            state_next.st      = ST_PRES; // RULE27
            state_next.tmr     = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dqOut      = state_reg.dqLevel;
    assign dqOe       = state_reg.drive;
    assign convStart  = state_reg.convStart;
    assign commitAddr = state_reg.commit;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_openDrain;
        dqOut == 1'b0 && (state_reg.st != ST_IDLE || !dqOe);
    endproperty
    a_openDrain: assert property (p_openDrain) // RULE2
        else $error("device drove high or drove while passive");

    // A slot left open while passive would keep the next fall from opening a slot
    logic inSlotNow;
    assign inSlotNow = state_reg.inSlot && state_reg.st == ST_IDLE;

    property p_busReset;
        !dqIn && state_reg.lowCnt == RST_CYC - 1'b1
            |=> state_reg.st == ST_IDLE && !dqOe ##1 !inSlotNow;
    endproperty
    a_busReset: assert property (p_busReset) // RULE4
        else $error("long low did not reset interface");

    property p_lsbFirst;
        bitEv && state_reg.st == ST_ROMCMD
            |=> state_reg.rxSh[7] == $past(dqIn);
    endproperty
    a_lsbFirst: assert property (p_lsbFirst) // RULE1
        else $error("received bit not shifted in at msb end");

    property p_skip;
        bitEv && state_reg.st == ST_ROMCMD && state_reg.bitCnt == BIT_LAST
            && rxNew == CMD_SKIP |=> state_reg.st == ST_FUNC;
    endproperty
    a_skip: assert property (p_skip) // RULE11
        else $error("skip did not select device");

    property p_matchFail;
        bitEv && state_reg.st == ST_MATCH && state_reg.idx == ID_LAST
            && (state_reg.miss || dqIn != ID_CODE[ID_LAST])
            |=> state_reg.st == ST_IDLE;
    endproperty
    a_matchFail: assert property (p_matchFail) // RULE10
        else $error("mismatching code was accepted");

    property p_convOnce;
        convStart |=> !convStart && state_reg.conv;
    endproperty
    a_convOnce: assert property (p_convOnce) // RULE13
        else $error("conversion start not a single pulse");

    property p_wrap;
        bitEv && state_reg.st == ST_RDSTAGE && state_reg.bitCnt == BIT_LAST
            && state_reg.ptr == BIT_LAST |=> state_reg.ptr == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) // RULE20
        else $error("stage pointer did not wrap");

    property p_unknownCmd;
        bitEv && state_reg.st == ST_FUNC && state_reg.bitCnt == BIT_LAST
            && rxNew != CMD_CONVERT && rxNew != CMD_RD_SENSOR
            && rxNew != CMD_RD_STAGE |=> state_reg.st == ST_IDLE ##1 !dqOe;
    endproperty
    a_unknownCmd: assert property (p_unknownCmd) // RULE28
        else $error("unknown command did not go passive");

    property p_commit;
        bitEv && state_reg.st == ST_ADDR && state_reg.bitCnt == BIT_LAST
            && !stageWrStb |=> commitAddr == $past(rxNew);
    endproperty
    a_commit: assert property (p_commit) // RULE22
        else $error("stage read address not stored as commit target");

    property p_sensorEnd;
        bitEv && state_reg.st == ST_RDSENS && state_reg.bitCnt == BIT_LAST
            && state_reg.byteCnt == SB_CRC |=> state_reg.st == ST_IDLE;
    endproperty
    a_sensorEnd: assert property (p_sensorEnd) // RULE16
        else $error("sensor read did not end after crc byte");

endmodule

// ===== sim/sws_master_model.sv
`timescale 1ns/100ps
module sws_master_model
    import sws_pkg::*;
#(
    parameter int SLOT_C = SLOT_CYC
)(
    input  wire logic mclk,
    input  wire logic dqOe,
    output logic      dqIn
);
    // ********************************
    // Bus master side of the data line
    // ********************************
    logic masterLow = 1'b0;
    // Weak pull-up only: device has its own supply, so polling works
    assign dqIn = ~(masterLow | dqOe);
    // Pull low for n cycles, then release
    task automatic lowFor(input int n);
        // Start on an edge, a high cycle after any earlier release
        @(posedge mclk);
        masterLow <= 1'b1;
        repeat (n) @(posedge mclk);
        masterLow <= 1'b0;
    endtask
    // Held a little past the device threshold
    task automatic busReset(input int rstCyc);
        lowFor(rstCyc + 10);
        @(posedge mclk);
    endtask
    // Slot outlasts the device window, so slots never overlap
    task automatic slot(input logic wBit, output logic rBit);
        lowFor(wBit ? 2 : SLOT_C + 5);
        // Sample mid-slot, while a device zero still stands
        repeat (SLOT_C / 2) @(posedge mclk);
        rBit = dqIn;
        repeat (wBit ? SLOT_C : 10) @(posedge mclk);
    endtask
    task automatic writeByte(input logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++) begin
            slot(b[i], r);
        end
    endtask
    task automatic readBits(input int n, output logic [7:0] v);
        v = 8'h00;
        for (int i = 0; i < n; i++) begin
            slot(1'b1, v[i]);
        end
    endtask
endmodule

// ===== sim/sws_slave_tb.sv
`timescale 1ns/100ps
module sws_slave_tb
    import sws_pkg::*;
;
    // ********************************
    // Bench signals and design
    // ********************************
    // Short slots keep the run small; bus reset outlasts any slot low
    localparam int RST_C = 200;
    localparam int PRES_C = 50;
    localparam int PRES_W = 20;
    localparam int SLOT_C = 40;
    logic        mclk, rst, dqIn, dqOut, dqOe, convDone, stageWrStb;
    logic        convStart;
    logic [3:0]  locPins;
    logic [15:0] tempIn;
    logic [63:0] stageData;
    logic [7:0]  stageWrAddr, commitAddr, v;
    int          fail_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          starts = 0;

    sws_slave #(
        .RST_CYC   (16'(RST_C)),
        .PRES_LEN  (16'(PRES_C)),
        .PRES_WAIT (16'(PRES_W)),
        .SLOT      (16'(SLOT_C))
    ) sws_slave_inst (
        .mclk(mclk), .rst(rst), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .locPins(locPins), .convDone(convDone), .tempIn(tempIn),
        .stageData(stageData), .stageWrStb(stageWrStb),
        .stageWrAddr(stageWrAddr), .convStart(convStart),
        .commitAddr(commitAddr));
    sws_master_model #(.SLOT_C(SLOT_C)) sws_master_model_inst (
        .mclk(mclk), .dqOe(dqOe), .dqIn(dqIn));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Cycle ceiling well above the four scenarios together
    always @(posedge mclk) begin
        cyc++;
        if (convStart === 1'b1) starts++;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bus reset, then time the presence answer
    task automatic presence;
        int n;
        int len;
        n = 0;
        len = 0;
        sws_master_model_inst.busReset(RST_C);
        while (dqOe !== 1'b1 && n < 4000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(n >= PRES_W && n <= PRES_W + 4, 1);
        while (dqOe === 1'b1 && len < 200) begin
            @(posedge mclk);
            #1;
            len++;
        end
        check(len, PRES_C);
    endtask
    task automatic test_commit;
        check(commitAddr, 8'h00);
        stageWrStb <= 1'b1;
        stageWrAddr <= 8'h08;
        @(posedge mclk);
        stageWrStb <= 1'b0;
        @(posedge mclk);
        #1;
        check(commitAddr, 8'h08);
    endtask
    // Status slots answer busy, then done after the result lands
    task automatic test_convert;
        presence;
        sws_master_model_inst.writeByte(CMD_SKIP);
        sws_master_model_inst.writeByte(CMD_CONVERT);
        check(starts, 1);
        sws_master_model_inst.readBits(1, v);
        check(v[0], 1'b0);
        check(dqOut, 1'b0);
        @(posedge mclk);
        convDone <= 1'b1;
        tempIn <= 16'h0191;
        @(posedge mclk);
        convDone <= 1'b0;
        sws_master_model_inst.readBits(1, v);
        check(v[0], 1'b1);
        check(starts, 1);
    endtask
    // Reference CRC step, LSB first, reflected x^8+x^5+x^4+1
    function automatic logic [7:0] crcAdd(input logic [7:0] c,
                                          input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        end
        return c;
    endfunction
    // Stage read from the last byte: wraps, then CRC of all ten bytes
    task automatic test_stage;
        logic [7:0] c;
        presence;
        sws_master_model_inst.writeByte(CMD_SKIP);
        sws_master_model_inst.writeByte(CMD_RD_STAGE);
        sws_master_model_inst.writeByte(8'h07);
        check(commitAddr, 8'h07);
        c = crcAdd(crcAdd(8'h00, CMD_RD_STAGE), 8'h07);
        for (int i = 0; i < 8; i++) begin
            sws_master_model_inst.readBits(8, v);
            check(v, stageData[8 * ((i + 7) % 8) +: 8]);
            c = crcAdd(c, stageData[8 * ((i + 7) % 8) +: 8]);
        end
        sws_master_model_inst.readBits(8, v);
        check(v, c);
    endtask
    // Family nibble first, then a reset cuts the transfer short
    task automatic test_readid;
        presence;
        sws_master_model_inst.writeByte(CMD_READID);
        sws_master_model_inst.readBits(4, v);
        check(v[3:0], FAMILY_DEF[3:0]);
        presence;
        check(dqOe, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        convDone = 1'b0;
        tempIn = 16'h0000;
        locPins = 4'h9;
        stageData = 64'h0706_0504_0302_0100;
        stageWrStb = 1'b0;
        stageWrAddr = 8'h00;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        test_commit;
        test_convert;
        test_stage;
        test_readid;
        print_verdict;
    end
endmodule
